// ---- dv/pes_motor_model.sv ----
// Linear motor and scale model: movement pulses while told to move.
// Assumes the bench clock; each pulse is two clocks high, two low.
`timescale 1ns/1ps
module pes_motor_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic move_en_i,
  output logic pulse_o
);
  logic [1:0] ph_reg;
  // Phase counter; a resting motor leaves the line low, as a scale at rest
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= move_en_i ? ph_reg + 2'h1 : 2'h0;
    end
  end
  assign pulse_o = ph_reg[1];
endmodule

// ---- dv/pes_top_properties.sv ----
// Port checker for the stop supervisor and its register port.
// Assumes a bind onto pes_top and a single clock domain.
`timescale 1ns/1ps
module pes_top_properties (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic FORCE_ON_I,
  input wire logic [2:0] OVL_CURVE_O,
  input wire logic EST_ERR_O,
  input wire logic SET_ERR_O,
  input wire logic STOPPED_O,
  input wire logic JUDGING_O
);
  // ****************
  // Decodes and sequences
  // ****************
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // Write decodes seen at the register port
  wire wr_curve = WR_I && ADDR_I == 16'h3929;
  wire wr_meth = WR_I && ADDR_I == 16'h3920;
  wire clr_err = WR_I && ADDR_I == 16'h3A00 && WDATA_I[0];
  sequence judge_end;
    JUDGING_O ##1 !JUDGING_O;
  endsequence
  sequence force_start;
    !FORCE_ON_I ##1 FORCE_ON_I;
  endsequence
  // ****************
  // Assertions
  // ****************
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not zero outside read cycle");
  curve_write_a: assert property (wr_curve |=>
    OVL_CURVE_O == ($past(WDATA_I) > 16'h0007 ? 3'h7 : $past(WDATA_I[2:0])))
    else $error("curve output does not follow write");
  set_err_a: assert property (wr_meth |=> ##1 SET_ERR_O == ($past(WDATA_I, 2) == 16'h0000))
    else $error("setting error does not track method");
  err_rise_a: assert property ($rose(EST_ERR_O) |-> $past(JUDGING_O))
    else $error("estimation error raised outside judgment");
  err_hold_a: assert property (EST_ERR_O && !clr_err |=> EST_ERR_O)
    else $error("estimation error dropped without clear");
  judge_start_a: assert property ($rose(JUDGING_O) |-> !$past(FORCE_ON_I))
    else $error("judgment began while force applied");
  force_restart_a: assert property (force_start ##0 JUDGING_O |-> ##[1:2] !JUDGING_O)
    else $error("new force did not restart");
  stop_ends_a: assert property ($rose(STOPPED_O) |-> $past(JUDGING_O) ##[0:1] !JUDGING_O)
    else $error("stop judged outside judgment");
  judge_exit_a: assert property (judge_end |-> STOPPED_O || EST_ERR_O || FORCE_ON_I
    || $past(FORCE_ON_I) || $past(WR_I) || $past(WR_I, 2))
    else $error("judgment ended without cause");
endmodule

bind pes_top pes_top_properties pes_top_properties_inst (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .FORCE_ON_I(FORCE_ON_I), .OVL_CURVE_O(OVL_CURVE_O), .EST_ERR_O(EST_ERR_O),
  .SET_ERR_O(SET_ERR_O), .STOPPED_O(STOPPED_O), .JUDGING_O(JUDGING_O));

// ---- dv/pes_top_tb_top.sv ----
// Testbench for the stop supervisor: register port tasks and scenarios.
// Assumes short time bases: 50 clocks a ms, 5 clocks a filter unit.
`timescale 1ns/1ps
module pes_top_tb_top;
  logic mclk, rst_n, wr, rd, force_on, move_en, move_pulse;
  logic [15:0] addr, wdata, rdata;
  logic signed [15:0] force_cmd, force_filt;
  logic [2:0] curve;
  logic est_err, set_err, stopped, judging, irq;
  int bad_count, checked;
  // ****************
  // Instances and clock
  // ****************
  pes_top #(.MS_CYCLES(50), .UNIT_CYCLES(5)) pes_top_inst (.MCLK_I(mclk), .RSTN_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .FORCE_ON_I(force_on), .FORCE_CMD_I(force_cmd), .MOVE_PULSE_I(move_pulse),
    .FORCE_FILT_O(force_filt), .OVL_CURVE_O(curve), .EST_ERR_O(est_err),
    .SET_ERR_O(set_err), .STOPPED_O(stopped), .JUDGING_O(judging), .IRQ_O(irq));
  pes_motor_model pes_motor_model_inst (.clk_i(mclk), .rstn_i(rst_n), .move_en_i(move_en),
    .pulse_o(move_pulse));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ****************
  // Tasks
  // ****************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Idle cycle after each strobe so no strobe is driven twice in one step
  task wr_reg(input logic [15:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task rd_reg(input logic [15:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // Sample mid-cycle, while the read data stand
    @(negedge mclk);
    check(rdata, exp);
    @(posedge mclk);
  endtask
  // Bounded wait: 0 waits for the error flag, 1 for the stop flag
  task wait_hi(input int w, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      if ((w == 0 ? est_err : stopped) === 1'b1) break;
    end
    if (i == n) begin
      bad_count++;
      results;
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    force_on = 1'b0;
    force_cmd = 16'sh0000;
    move_en = 1'b0;
    bad_count = 0;
    checked = 0;
    cyc(4);
    rst_n <= 1'b1;
    @(posedge mclk);
    // Power-on values, unmapped space and clamping
    rd_reg(16'h3927, 16'h03E8);
    rd_reg(16'h3928, 16'h0064);
    rd_reg(16'h3929, 16'h0000);
    rd_reg(16'h3A05, 16'h0000);
    check(set_err, 1'b1);
    wr_reg(16'h3927, 16'hFFFF);
    rd_reg(16'h3927, 16'h7FFF);
    wr_reg(16'h3928, 16'hFFFF);
    rd_reg(16'h3928, 16'h09C4);
    for (int c = 0; c < 10; c++) begin
      wr_reg(16'h3929, 16'(c));
      check(curve, (c > 7) ? 16'h0007 : 16'(c));
    end
    rd_reg(16'h3929, 16'h0007);
    $display("test registers done");
    // Every method code; the last one, restoration, must ignore force
    for (int m = 0; m < 4; m++) begin
      wr_reg(16'h3920, 16'(m));
      cyc(1);
      check(set_err, m == 0);
    end
    force_cmd <= 16'sh03E8;
    force_on <= 1'b1;
    cyc(5);
    check(force_filt, 16'h03E8);
    force_on <= 1'b0;
    force_cmd <= 16'sh0000;
    cyc(10);
    check(judging, 1'b0);
    $display("test methods done");
    // Filter, then a quiet motor reaching the stop judgment
    wr_reg(16'h3A00, 16'h0007);
    wr_reg(16'h3925, 16'h0002);
    wr_reg(16'h3926, 16'h0004);
    wr_reg(16'h3927, 16'h0014);
    wr_reg(16'h3928, 16'h0064);
    wr_reg(16'h3A01, 16'h0001);
    wr_reg(16'h3920, 16'h0002);
    force_cmd <= 16'sh03E8;
    force_on <= 1'b1;
    cyc(40);
    check(force_filt > 0 && force_filt < 16'sh03E8, 1'b1);
    wr_reg(16'h3928, 16'h0000);
    cyc(1);
    check(force_filt, 16'h03E8);
    force_on <= 1'b0;
    force_cmd <= 16'sh0000;
    cyc(3);
    check(force_filt, 16'h0000);
    check(judging, 1'b1);
    cyc(150);
    check(stopped, 1'b0);
    wait_hi(1, 300);
    cyc(2);
    check(judging, 1'b0);
    check(est_err, 1'b0);
    rd_reg(16'h3A00, 16'h0004);
    wr_reg(16'h3A00, 16'h0004);
    $display("test stop done");
    // Moving motor, a restart mid-judgment, then the timeout error
    wr_reg(16'h3927, 16'h0003);
    move_en <= 1'b1;
    force_on <= 1'b1;
    cyc(5);
    check(stopped, 1'b0);
    force_on <= 1'b0;
    cyc(100);
    force_on <= 1'b1;
    cyc(5);
    force_on <= 1'b0;
    cyc(120);
    check(est_err, 1'b0);
    wait_hi(0, 200);
    check(irq, 1'b1);
    check(stopped, 1'b0);
    move_en <= 1'b0;
    rd_reg(16'h3A00, 16'h0001);
    wr_reg(16'h3A01, 16'h0000);
    check(irq, 1'b0);
    force_on <= 1'b1;
    cyc(5);
    force_on <= 1'b0;
    cyc(5);
    check(judging, 1'b0);
    check(est_err, 1'b1);
    wr_reg(16'h3A00, 16'h0001);
    check(est_err, 1'b0);
    $display("test timeout done");
    results;
  end
endmodule

// ---- rtl/pes_cfg.svh ----
// Constants for the pole estimation stop supervisor: offsets, fields,
// reset values, limits and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PES_CFG_SVH
`define PES_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PES_OFS_METHOD 16'h3920
`define PES_OFS_STOP_MOVE 16'h3925
`define PES_OFS_STOP_TIME 16'h3926
`define PES_OFS_LIMIT 16'h3927
`define PES_OFS_FILTER 16'h3928
`define PES_OFS_CURVE 16'h3929
`define PES_OFS_STATUS 16'h3A00
`define PES_OFS_MASK 16'h3A01

// ****************************************************************
// Reset values and upper limits
// ****************************************************************
`define PES_RST_METHOD 16'h0000
`define PES_RST_STOP_MOVE 16'h0028
`define PES_RST_STOP_TIME 16'h0028
`define PES_RST_LIMIT 16'h03E8
`define PES_RST_FILTER 16'h0064
`define PES_RST_CURVE 16'h0000
`define PES_RST_MASK 16'h0000
`define PES_MAX_15BIT 16'h7FFF
`define PES_MAX_FILTER 16'h09C4
`define PES_MAX_CURVE 16'h0007
`define PES_MAX_METHOD 16'h0003
`define PES_METHOD_ESTIMATE 2'h2
`define PES_METHOD_NONE 2'h0

// ****************************************************************
// Status and mask fields
// ****************************************************************
`define PES_BIT_EST_ERR 0
`define PES_BIT_SET_ERR 1
`define PES_BIT_STOPPED 2
`define PES_NUM_EVENTS 3

// ****************************************************************
// Timing
// ****************************************************************
`define PES_CLK_PERIOD_PS 5000
`define PES_MS_TIME_PS 1000000000
`define PES_FILT_UNIT_PS 10000000
`define PES_WINDOW_MS 2
`define PES_MS_CYCLES (`PES_MS_TIME_PS / `PES_CLK_PERIOD_PS)
`define PES_UNIT_CYCLES (`PES_FILT_UNIT_PS / `PES_CLK_PERIOD_PS)

`endif

// ---- rtl/pes_force_filter.sv ----
// First-order low-pass on the estimation force command.
// Assumes a strobe every 0.01 ms; tau counts those strobes.
`timescale 1ns/1ps
`include "pes_cfg.svh"

module pes_force_filter (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic unit_tick_i,
  input pes_pkg::pes_filt_cfg_t cfg_i,
  input wire logic signed [15:0] force_i,
  output logic signed [15:0] force_o
);
  import pes_pkg::*;

  logic signed [31:0] acc_reg;
  logic signed [15:0] out_reg;
  // Sixteen fraction bits keep small steps from stalling at large tau
  wire signed [32:0] target = {force_i[15], force_i, 16'h0000};
  wire signed [32:0] diff = target - {acc_reg[31], acc_reg};
  wire signed [32:0] step = diff / $signed({21'h000000, cfg_i.tau});
  wire signed [32:0] acc_sum = {acc_reg[31], acc_reg} + step;
  wire zero_tau = (cfg_i.tau == 12'h000);

  // Step, or bypass when tau is zero or not in estimation
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_reg <= '0;
      out_reg <= '0;
    end else if (cfg_i.bypass || zero_tau) begin
      acc_reg <= target[31:0];
      out_reg <= force_i;
    end else if (unit_tick_i) begin
      acc_reg <= acc_sum[31:0];
      out_reg <= acc_sum[31:16];
    end
  end

  assign force_o = out_reg;

endmodule

// ---- rtl/pes_pkg.sv ----
// Types shared by the pole estimation stop supervisor modules.
// Assumes pes_cfg.svh is on the include path.
`include "pes_cfg.svh"

package pes_pkg;

  // Supervisor states, one-hot
  typedef enum logic [3:0] {
    PES_ST_IDLE = 4'b0001,
    PES_ST_FORCE = 4'b0010,
    PES_ST_JUDGE = 4'b0100,
    PES_ST_HALT = 4'b1000
  } pes_state_t;

  // Time base strobes
  typedef struct packed {
    logic unit_tick;
    logic ms_tick;
    logic win_tick;
  } pes_tick_t;

  // Filter configuration
  typedef struct packed {
    logic bypass;
    logic [11:0] tau;
  } pes_filt_cfg_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pes_bus_req_t;

endpackage

// ---- rtl/pes_tick_gen.sv ----
// Time base: 0.01 ms filter strobe, 1 ms strobe and movement window strobe.
// Assumes one clock; clear realigns the millisecond and window phases.
`timescale 1ns/1ps
`include "pes_cfg.svh"

module pes_tick_gen #(
  parameter int MS_CYCLES = `PES_MS_CYCLES,
  parameter int UNIT_CYCLES = `PES_UNIT_CYCLES,
  parameter int WIN_MS = `PES_WINDOW_MS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  output pes_pkg::pes_tick_t tick_o
);
  import pes_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam int UW = $clog2(UNIT_CYCLES + 1);
  localparam int WW = $clog2(WIN_MS + 1);

  logic [MSW-1:0] ms_cnt_reg;
  logic [UW-1:0] unit_cnt_reg;
  logic [WW-1:0] win_cnt_reg;
  pes_tick_t tick_reg;
  wire ms_last = (ms_cnt_reg == MSW'(MS_CYCLES - 1));
  wire unit_last = (unit_cnt_reg == UW'(UNIT_CYCLES - 1));
  wire win_last = ms_last && (win_cnt_reg == WW'(WIN_MS - 1));

  // Free counters; the filter strobe is never realigned
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ms_cnt_reg <= '0;
      unit_cnt_reg <= '0;
      win_cnt_reg <= '0;
      tick_reg <= '0;
    end else begin
      unit_cnt_reg <= unit_last ? '0 : unit_cnt_reg + UW'(1);
      ms_cnt_reg <= (clear_i || ms_last) ? '0 : ms_cnt_reg + MSW'(1);
      win_cnt_reg <= (clear_i || win_last) ? '0 : (ms_last ? win_cnt_reg + WW'(1) : win_cnt_reg);
      tick_reg.unit_tick <= unit_last;
      tick_reg.ms_tick <= ms_last && !clear_i;
      tick_reg.win_tick <= win_last && !clear_i;
    end
  end

  assign tick_o = tick_reg;

endmodule

// ---- rtl/pes_top.sv ----
// Pole estimation stop supervisor: stop-judgment timeout, force filter,
// overload curve select and the register and interrupt logic around them.
// Assumes force on/off and force value from logic on this clock, and a
// raw movement pulse from the scale pin, one pulse per counted step.
//
// Operation
// - Stop-judgment limit time in ms is writable from 0 to 32767 and starts at 1000.
// - Timing of the stop-judgment interval begins at force removal and ends once the motor is judged stopped.
// - Expiry of the limit before a stop judgment raises estimation error 61.1.
// - Limit, filter and stop settings act only while the detection method is 2, estimation.
// - The estimation force is low-pass filtered with a constant of 0 to 2500 units of 0.01 ms, starting at 100.
// - A filter constant of zero passes each force command straight through as a step.
// - One of eight overload curves is chosen by a setting from 0 to 7, starting at 0.
// - The motor is stopped once pulses per 2 ms window stay at or below the threshold for the stop time.
// - Method 0 is unspecified and flags a setting error 60.0, 1 reserved, 2 estimation, 3 restoration.
`timescale 1ns/1ps
`include "pes_cfg.svh"

module pes_top #(
  parameter int MS_CYCLES = `PES_MS_CYCLES,
  parameter int UNIT_CYCLES = `PES_UNIT_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic FORCE_ON_I,
  input wire logic signed [15:0] FORCE_CMD_I,
  input wire logic MOVE_PULSE_I,
  output logic signed [15:0] FORCE_FILT_O,
  output logic [2:0] OVL_CURVE_O,
  output logic EST_ERR_O,
  output logic SET_ERR_O,
  output logic STOPPED_O,
  output logic JUDGING_O,
  output logic IRQ_O
);
  import pes_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int NEV = `PES_NUM_EVENTS;

  pes_bus_req_t req;
  pes_state_t state_reg, state_next;
  logic [1:0] method_reg;
  logic [14:0] stop_move_reg;
  logic [14:0] stop_time_reg;
  logic [14:0] limit_reg;
  logic [11:0] filter_reg;
  logic [2:0] curve_reg;
  logic [NEV-1:0] status_reg, status_next;
  logic [NEV-1:0] mask_reg;
  logic [15:0] rdata_reg;
  logic set_err_reg;
  logic mv_sync1_reg, mv_sync2_reg, mv_prev_reg;
  logic [15:0] win_cnt_reg;
  logic [15:0] quiet_ms_reg;
  logic [15:0] elapsed_ms_reg;
  logic stopped_reg;
  pes_tick_t tick;
  pes_filt_cfg_t filt_cfg;

  // Clamp a written value to its legal top
  function automatic logic [15:0] pes_clamp(input logic [15:0] v, input logic [15:0] top);
    pes_clamp = (v > top) ? top : v;
  endfunction

  // Address match with a write strobe
  function automatic logic pes_hit(input pes_bus_req_t r, input logic [15:0] ofs);
    pes_hit = r.wr && (r.addr == ofs);
  endfunction

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign req.wr = WR_I;
  assign req.rd = RD_I;
  assign req.addr = ADDR_I;
  assign req.wdata = WDATA_I;

  wire wr_method = pes_hit(req, `PES_OFS_METHOD);
  wire wr_stop_move = pes_hit(req, `PES_OFS_STOP_MOVE);
  wire wr_stop_time = pes_hit(req, `PES_OFS_STOP_TIME);
  wire wr_limit = pes_hit(req, `PES_OFS_LIMIT);
  wire wr_filter = pes_hit(req, `PES_OFS_FILTER);
  wire wr_curve = pes_hit(req, `PES_OFS_CURVE);
  wire wr_status = pes_hit(req, `PES_OFS_STATUS);
  wire wr_mask = pes_hit(req, `PES_OFS_MASK);

  // Out-of-range writes saturate rather than wrap, except mask writes, which keep only the low bits, so a stray large value never shortens a time
  wire [15:0] method_w = pes_clamp(req.wdata, `PES_MAX_METHOD);
  wire [15:0] limit_w = pes_clamp(req.wdata, `PES_MAX_15BIT);
  wire [15:0] move_w = pes_clamp(req.wdata, `PES_MAX_15BIT);
  wire [15:0] time_w = pes_clamp(req.wdata, `PES_MAX_15BIT);
  wire [15:0] filter_w = pes_clamp(req.wdata, `PES_MAX_FILTER);
  wire [15:0] curve_w = pes_clamp(req.wdata, `PES_MAX_CURVE);

  // Configuration registers
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      method_reg <= 2'(`PES_RST_METHOD);
      stop_move_reg <= 15'(`PES_RST_STOP_MOVE);
      stop_time_reg <= 15'(`PES_RST_STOP_TIME);
      limit_reg <= 15'(`PES_RST_LIMIT);
      filter_reg <= 12'(`PES_RST_FILTER);
      curve_reg <= 3'(`PES_RST_CURVE);
      mask_reg <= NEV'(`PES_RST_MASK);
    end else begin
      if (wr_method) method_reg <= method_w[1:0];
      if (wr_stop_move) stop_move_reg <= move_w[14:0];
      if (wr_stop_time) stop_time_reg <= time_w[14:0];
      if (wr_limit) limit_reg <= limit_w[14:0];
      if (wr_filter) filter_reg <= filter_w[11:0];
      if (wr_curve) curve_reg <= curve_w[2:0];
      if (wr_mask) mask_reg <= req.wdata[NEV-1:0];
    end
  end

  // Read mux; unmapped offsets read zero
  wire [15:0] rd_mux =
    (req.addr == `PES_OFS_METHOD) ? {14'h0000, method_reg} :
    (req.addr == `PES_OFS_STOP_MOVE) ? {1'b0, stop_move_reg} :
    (req.addr == `PES_OFS_STOP_TIME) ? {1'b0, stop_time_reg} :
    (req.addr == `PES_OFS_LIMIT) ? {1'b0, limit_reg} :
    (req.addr == `PES_OFS_FILTER) ? {4'h0, filter_reg} :
    (req.addr == `PES_OFS_CURVE) ? {13'h0000, curve_reg} :
    (req.addr == `PES_OFS_STATUS) ? {13'h0000, status_reg} :
    (req.addr == `PES_OFS_MASK) ? {13'h0000, mask_reg} :
    16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= req.rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************************************
  // Method decode
  // ****************************************************************
  wire est_mode = (method_reg == `PES_METHOD_ESTIMATE);
  wire no_method = (method_reg == `PES_METHOD_NONE);

  // ****************************************************************
  // Time base and movement counting
  // ****************************************************************
  wire force_start = est_mode && FORCE_ON_I && (state_reg != PES_ST_FORCE);
  wire force_end = (state_reg == PES_ST_FORCE) && !FORCE_ON_I;

  pes_tick_gen #(
    .MS_CYCLES(MS_CYCLES),
    .UNIT_CYCLES(UNIT_CYCLES),
    .WIN_MS(`PES_WINDOW_MS)
  ) pes_tick_gen_inst (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .clear_i(force_end),
    .tick_o(tick)
  );

  // Scale pulse is asynchronous; only the second stage feeds the edge detect
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mv_sync1_reg <= 1'b0;
      mv_sync2_reg <= 1'b0;
      mv_prev_reg <= 1'b0;
    end else begin
      mv_sync1_reg <= MOVE_PULSE_I;
      mv_sync2_reg <= mv_sync1_reg;
      mv_prev_reg <= mv_sync2_reg;
    end
  end

  wire mv_edge = mv_sync2_reg && !mv_prev_reg;
  // Count saturates so a fast move cannot wrap into a false quiet window
  wire [15:0] win_cnt_inc = (win_cnt_reg == 16'hFFFF) ? win_cnt_reg : win_cnt_reg + 16'h0001;
  wire win_quiet = (win_cnt_reg <= {1'b0, stop_move_reg});
  wire [15:0] quiet_add = quiet_ms_reg + 16'(`PES_WINDOW_MS);
  wire [15:0] quiet_sum = (quiet_ms_reg[15]) ? quiet_ms_reg : quiet_add;
  wire judging = (state_reg == PES_ST_JUDGE);

  // Window pulse count and quiet time accumulated during judgment
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      win_cnt_reg <= 16'h0000;
      quiet_ms_reg <= 16'h0000;
    end else if (!judging) begin
      win_cnt_reg <= 16'h0000;
      quiet_ms_reg <= 16'h0000;
    end else if (tick.win_tick) begin
      win_cnt_reg <= mv_edge ? 16'h0001 : 16'h0000;
      quiet_ms_reg <= win_quiet ? quiet_sum : 16'h0000;
    end else if (mv_edge) begin
      win_cnt_reg <= win_cnt_inc;
    end
  end

  // Stop decision needs at least one evaluated window
  wire stop_met = judging && (quiet_ms_reg != 16'h0000) && (quiet_ms_reg >= {1'b0, stop_time_reg});

  // ****************************************************************
  // Stop-judgment timer
  // ****************************************************************
  wire [15:0] elapsed_inc = elapsed_ms_reg[15] ? elapsed_ms_reg : elapsed_ms_reg + 16'h0001;
  wire limit_hit = judging && (elapsed_ms_reg >= {1'b0, limit_reg});

  // Timer restarts on every force command and at force removal
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      elapsed_ms_reg <= 16'h0000;
    end else if (force_start || force_end) begin
      elapsed_ms_reg <= 16'h0000;
    end else if (judging && tick.ms_tick) begin
      elapsed_ms_reg <= elapsed_inc;
    end
  end

  // ****************************************************************
  // Supervisor state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PES_ST_IDLE: begin
        if (force_start) state_next = PES_ST_FORCE;
      end
      PES_ST_FORCE: begin
        if (!est_mode) state_next = PES_ST_IDLE;
        else if (!FORCE_ON_I) state_next = PES_ST_JUDGE;
      end
      PES_ST_JUDGE: begin
        // A stop in the expiry cycle counts as a stop, not an error
        if (!est_mode) state_next = PES_ST_IDLE;
        else if (stop_met) state_next = PES_ST_IDLE;
        else if (limit_hit) state_next = PES_ST_HALT;
        else if (force_start) state_next = PES_ST_FORCE;
      end
      PES_ST_HALT: begin
        // Further force pulses are ignored until the error is cleared or the method leaves estimation
        if (!status_reg[`PES_BIT_EST_ERR] || !est_mode) state_next = PES_ST_IDLE;
      end
      default: state_next = PES_ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= PES_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Status, interrupt and flags
  // ****************************************************************
  logic [NEV-1:0] ev_set;
  logic [NEV-1:0] ev_clr;
  assign ev_set[`PES_BIT_EST_ERR] = judging && est_mode && !stop_met && limit_hit;
  assign ev_set[`PES_BIT_SET_ERR] = no_method;
  assign ev_set[`PES_BIT_STOPPED] = judging && est_mode && stop_met;
  assign ev_clr = wr_status ? req.wdata[NEV-1:0] : '0;

  // Set beats a same-cycle write-one clear
  always_comb begin
    status_next = (status_reg & ~ev_clr) | ev_set;
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      status_reg <= '0;
      set_err_reg <= 1'b0;
      stopped_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      set_err_reg <= no_method;
      stopped_reg <= force_start ? 1'b0 : (stopped_reg || ev_set[`PES_BIT_STOPPED]);
    end
  end

  // ****************************************************************
  // Force filter
  // ****************************************************************
  assign filt_cfg.bypass = !est_mode;
  assign filt_cfg.tau = filter_reg;

  pes_force_filter pes_force_filter_inst (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .unit_tick_i(tick.unit_tick),
    .cfg_i(filt_cfg),
    .force_i(FORCE_CMD_I),
    .force_o(FORCE_FILT_O)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA_O = rdata_reg;
  assign OVL_CURVE_O = curve_reg;
  assign EST_ERR_O = status_reg[`PES_BIT_EST_ERR];
  assign SET_ERR_O = set_err_reg;
  assign STOPPED_O = stopped_reg;
  assign JUDGING_O = state_reg[2];
  assign IRQ_O = |(status_reg & mask_reg);

endmodule
